/* core/legacy_kbd_pkg.sv */
package legacy_kbd_pkg;

    // Register offsets within the operational space
    localparam logic [8:0] OFS_CONTROL = 9'h100;
    localparam logic [8:0] OFS_INPUT   = 9'h104;
    localparam logic [8:0] OFS_OUTPUT  = 9'h108;
    localparam logic [8:0] OFS_STATUS  = 9'h10c;

    // Legacy I/O port addresses
    localparam logic [15:0] PORT_DATA = 16'h0060;
    localparam logic [15:0] PORT_CMD  = 16'h0064;

    // Control field positions
    localparam int CTL_EMUL_EN    = 0;
    localparam int CTL_EMUL_INT   = 1;
    localparam int CTL_CP         = 2;
    localparam int CTL_BUF_IRQ_EN = 3;
    localparam int CTL_EXT_IRQ_EN = 4;
    localparam int CTL_A20_SEQ    = 5;
    localparam int CTL_KBD_ACT    = 6;
    localparam int CTL_MS_ACT     = 7;
    localparam int CTL_A20_STATE  = 8;

    // Status field positions
    localparam int ST_OUT_FULL     = 0;
    localparam int ST_IN_FULL      = 1;
    localparam int ST_CMD_DATA     = 3;
    localparam int ST_AUX_OUT_FULL = 5;

    // Reset values and special command
    localparam logic [8:0]  CONTROL_RESET = 9'h000;
    localparam logic [7:0]  BYTE_RESET    = 8'h00;
    localparam logic [7:0]  CMD_GATE_A20  = 8'hd1;

endpackage

/* core/edge_sync.sv */
`timescale 1ns/1ps

// Three-stage synchroniser with rising edge pulse; second and third must agree
module edge_sync
    import legacy_kbd_pkg::*;
(
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // Asynchronous input and results
    input  wire logic async_in,
    output logic      level_out,
    output logic      rise_pulse
);

    logic [2:0] sync_reg;
    logic       level_reg;

    // Stage one is read only by stage two
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sync_reg <= 3'h0;
        end else begin
            sync_reg <= {sync_reg[1:0], async_in};
        end
    end

    // Level changes only when stages two and three agree
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            level_reg <= 1'b0;
        end else if (sync_reg[1] == sync_reg[2]) begin
            level_reg <= sync_reg[2];
        end
    end

    assign level_out  = level_reg;
    assign rise_pulse = (sync_reg[1] == sync_reg[2]) && sync_reg[2] && !level_reg;

endmodule // edge_sync

/* core/legacy_kbd_emul.sv */
`timescale 1ns/1ps

// Functional notes
// - Four registers at 100h through 10Ch.
// - Port 60h read returns output, clears full.
// - Port 60h write captures, sets in-full, data.
// - Port 64h read returns status, no side effect.
// - Port 64h write captures, clears in-full, command.
// - Control bit 8 holds gate A20 state.
// - Mouse rising edge sets bit 7; 1 clears.
// - Keyboard rising edge sets bit 6; 1 clears.
// - D1h to 64h sets sequence flag, else clears.
// - Bit 4 passes external irqs to emulation.
// - Bit 3 drives irq while output full.
// - Bit 2 interrupts when output full falls.
// - Bit 1 read-only emulation interrupt condition.
// - Bit 0 enables trapping and irq lines.
// - Memory accesses have no flag side effects.
module legacy_kbd_emul
    import legacy_kbd_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // Operational register access (memory cycles)
    input  wire logic        mem_sel,
    input  wire logic        mem_write,
    input  wire logic [8:0]  mem_addr,
    input  wire logic [31:0] mem_wdata,
    output logic [31:0]      mem_rdata,
    // Legacy port I/O cycles
    input  wire logic        io_sel,
    input  wire logic        io_write,
    input  wire logic [15:0] io_addr,
    input  wire logic [7:0]  io_wdata,
    output logic [7:0]       io_rdata,
    output logic             io_claim,
    // Keyboard controller interrupt inputs (asynchronous pins)
    input  wire logic        kbc_kbd_irq,
    input  wire logic        kbc_mouse_irq,
    // Interrupt outputs
    output logic             keyboard_irq_line,
    output logic             mouse_irq_line,
    output logic             emulation_irq
);

    logic [8:0]  control_reg;
    logic [7:0]  input_reg;
    logic [7:0]  output_reg;
    logic [7:0]  status_reg;
    logic [31:0] mem_rdata_reg;
    logic [7:0]  io_rdata_reg;
    logic        io_claim_reg;
    logic        kbd_irq_reg;
    logic        mouse_irq_reg;
    logic        emul_irq_reg;
    logic        cp_event_reg;
    logic        kbd_level;
    logic        kbd_rise;
    logic        mouse_level;
    logic        mouse_rise;

    // Decode helper shared by the memory access paths
    function automatic logic hit(input logic [8:0] a, input logic [8:0] ofs);
        return a == ofs;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    edge_sync u_kbd_sync (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .async_in   (kbc_kbd_irq),
        .level_out  (kbd_level),
        .rise_pulse (kbd_rise)
    );

    edge_sync u_mouse_sync (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .async_in   (kbc_mouse_irq),
        .level_out  (mouse_level),
        .rise_pulse (mouse_rise)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Port cycle decode

    logic trap_en;
    logic p60_rd;
    logic p60_wr;
    logic p64_rd;
    logic p64_wr;
    logic mem_wr;

    assign trap_en = control_reg[CTL_EMUL_EN];
    assign p60_rd  = trap_en && io_sel && !io_write && io_addr == PORT_DATA;
    assign p60_wr  = trap_en && io_sel && io_write && io_addr == PORT_DATA;
    assign p64_rd  = trap_en && io_sel && !io_write && io_addr == PORT_CMD;
    assign p64_wr  = trap_en && io_sel && io_write && io_addr == PORT_CMD;
    assign mem_wr  = mem_sel && mem_write;

    ////////////////////////////////////////////////////////////////////////////
    // Control register

    // Edges set the active bits; an edge in the clearing cycle wins
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            control_reg <= CONTROL_RESET;
        end else begin
            if (mem_wr && hit(mem_addr, OFS_CONTROL)) begin
                control_reg[CTL_EMUL_EN]    <= mem_wdata[CTL_EMUL_EN];
                control_reg[CTL_CP]         <= mem_wdata[CTL_CP];
                control_reg[CTL_BUF_IRQ_EN] <= mem_wdata[CTL_BUF_IRQ_EN];
                control_reg[CTL_EXT_IRQ_EN] <= mem_wdata[CTL_EXT_IRQ_EN];
                control_reg[CTL_A20_SEQ]    <= mem_wdata[CTL_A20_SEQ];
                control_reg[CTL_A20_STATE]  <= mem_wdata[CTL_A20_STATE];
                if (mem_wdata[CTL_KBD_ACT]) begin
                    control_reg[CTL_KBD_ACT] <= 1'b0;
                end
                if (mem_wdata[CTL_MS_ACT]) begin
                    control_reg[CTL_MS_ACT] <= 1'b0;
                end
            end
            if (p64_wr) begin
                control_reg[CTL_A20_SEQ] <= (io_wdata == CMD_GATE_A20);
            end
            if (kbd_rise) begin
                control_reg[CTL_KBD_ACT] <= 1'b1;
            end
            if (mouse_rise) begin
                control_reg[CTL_MS_ACT] <= 1'b1;
            end
            control_reg[CTL_EMUL_INT] <= emul_irq_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input, output and status registers

    // Port writes capture the byte; memory writes store plainly
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            input_reg <= BYTE_RESET;
        end else if (p60_wr || p64_wr) begin
            input_reg <= io_wdata;
        end else if (mem_wr && hit(mem_addr, OFS_INPUT)) begin
            input_reg <= mem_wdata[7:0];
        end
    end

    // Output byte is written only by emulation software
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            output_reg <= BYTE_RESET;
        end else if (mem_wr && hit(mem_addr, OFS_OUTPUT)) begin
            output_reg <= mem_wdata[7:0];
        end
    end

    // Port 60h cycles and 64h writes move flags; memory writes to status carry no side effect
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            status_reg <= BYTE_RESET;
        end else if (p60_rd) begin
            status_reg[ST_OUT_FULL] <= 1'b0;
        end else if (p60_wr) begin
            status_reg[ST_IN_FULL]  <= 1'b1;
            status_reg[ST_CMD_DATA] <= 1'b0;
        end else if (p64_wr) begin
            status_reg[ST_IN_FULL]  <= 1'b0;
            status_reg[ST_CMD_DATA] <= 1'b1;
        end else if (mem_wr && hit(mem_addr, OFS_STATUS)) begin
            status_reg <= mem_wdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read paths

    // Memory reads: one cycle latency, unmapped reads as zero
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mem_rdata_reg <= 32'h0;
        end else if (mem_sel && !mem_write) begin
            if (hit(mem_addr, OFS_CONTROL)) begin
                mem_rdata_reg <= {23'h0, control_reg};
            end else if (hit(mem_addr, OFS_INPUT)) begin
                mem_rdata_reg <= {24'h0, input_reg};
            end else if (hit(mem_addr, OFS_OUTPUT)) begin
                mem_rdata_reg <= {24'h0, output_reg};
            end else if (hit(mem_addr, OFS_STATUS)) begin
                mem_rdata_reg <= {24'h0, status_reg};
            end else begin
                mem_rdata_reg <= 32'h0;
            end
        end
    end

    // Port reads: claim flags the cycle as trapped
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            io_rdata_reg <= BYTE_RESET;
            io_claim_reg <= 1'b0;
        end else begin
            io_claim_reg <= p60_rd || p60_wr || p64_rd || p64_wr;
            if (p60_rd) begin
                io_rdata_reg <= output_reg;
            end else if (p64_rd) begin
                io_rdata_reg <= status_reg;
            end else begin
                io_rdata_reg <= BYTE_RESET;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt lines

    logic out_full;
    logic aux_full;
    assign out_full = status_reg[ST_OUT_FULL];
    assign aux_full = status_reg[ST_AUX_OUT_FULL];

    // Lines follow the buffer flag; lines only while emulation is enabled
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            kbd_irq_reg   <= 1'b0;
            mouse_irq_reg <= 1'b0;
        end else begin
            kbd_irq_reg   <= trap_en && control_reg[CTL_BUF_IRQ_EN]
                             && out_full && !aux_full;
            mouse_irq_reg <= trap_en && control_reg[CTL_BUF_IRQ_EN]
                             && out_full && aux_full;
        end
    end

    // Falling output-full latches a pending event; cleared by disabling
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cp_event_reg <= 1'b0;
        end else if (p60_rd && out_full && control_reg[CTL_CP]) begin
            cp_event_reg <= 1'b1;
        end else if (!control_reg[CTL_CP]) begin
            cp_event_reg <= 1'b0;
        end
    end

    // Emulation interrupt condition; external path ignores enable bit
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            emul_irq_reg <= 1'b0;
        end else begin
            emul_irq_reg <= (control_reg[CTL_EXT_IRQ_EN] && (kbd_level || mouse_level))
                            || (trap_en && cp_event_reg)
                            || (trap_en && (status_reg[ST_IN_FULL]
                                || p60_wr || p64_wr));
        end
    end

    assign mem_rdata         = mem_rdata_reg;
    assign io_rdata          = io_rdata_reg;
    assign io_claim          = io_claim_reg;
    assign keyboard_irq_line = kbd_irq_reg;
    assign mouse_irq_line    = mouse_irq_reg;
    assign emulation_irq     = emul_irq_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    sequence s_port60_read;
        trap_en && io_sel && !io_write && io_addr == PORT_DATA;
    endsequence

    sequence s_port64_write;
        trap_en && io_sel && io_write && io_addr == PORT_CMD;
    endsequence

    AST_P60_RD_CLEARS: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_port60_read |=> !status_reg[ST_OUT_FULL] && io_claim && io_rdata == $past(output_reg))
        else $error("port 60h read did not clear output full");

    AST_P60_WR_FLAGS: assert property (@(posedge core_clk) disable iff (!rst_n)
        p60_wr |=> status_reg[ST_IN_FULL] && !status_reg[ST_CMD_DATA]
                   && input_reg == $past(io_wdata))
        else $error("port 60h write flags wrong");

    AST_P64_RD_STABLE: assert property (@(posedge core_clk) disable iff (!rst_n)
        p64_rd && !mem_wr |=> $stable(status_reg) && io_rdata == $past(status_reg))
        else $error("port 64h read changed status");

    AST_P64_WR_FLAGS: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_port64_write |=> !status_reg[ST_IN_FULL] && status_reg[ST_CMD_DATA])
        else $error("port 64h write flags wrong");

    AST_GA20_SEQ: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_port64_write |=> control_reg[CTL_A20_SEQ] == ($past(io_wdata) == CMD_GATE_A20))
        else $error("gate A20 sequence flag wrong");

    AST_KBD_EDGE: assert property (@(posedge core_clk) disable iff (!rst_n)
        kbd_rise |=> control_reg[CTL_KBD_ACT])
        else $error("keyboard edge not recorded");

    AST_MS_EDGE: assert property (@(posedge core_clk) disable iff (!rst_n)
        mouse_rise |=> control_reg[CTL_MS_ACT])
        else $error("mouse edge not recorded");

    AST_IRQ_LINE: assert property (@(posedge core_clk) disable iff (!rst_n)
        trap_en && control_reg[CTL_BUF_IRQ_EN] && out_full && !aux_full ##1 1
        |-> keyboard_irq_line && !mouse_irq_line)
        else $error("keyboard line not driven while output full");

    AST_EXT_PASS: assert property (@(posedge core_clk) disable iff (!rst_n)
        control_reg[CTL_EXT_IRQ_EN] && kbd_level |=> emulation_irq ##1 control_reg[CTL_EMUL_INT])
        else $error("external irq not passed to emulation interrupt");

    AST_DISABLED: assert property (@(posedge core_clk) disable iff (!rst_n)
        !trap_en && io_sel |=> !io_claim)
        else $error("port cycle trapped while disabled");

endmodule // legacy_kbd_emul

/* tb/legacy_host_model.sv */
`timescale 1ns/1ps

// Legacy host software: one port cycle at a time, launched on the falling edge
module legacy_host_model (
    // Clock
    input  wire logic   core_clk,
    // Port cycle request
    output logic        io_sel,
    output logic        io_write,
    output logic [15:0] io_addr,
    output logic [7:0]  io_wdata
);
    // Idle bus at time zero
    initial begin
        io_sel = 1'b0;
        io_write = 1'b0;
        io_addr = 16'h0000;
        io_wdata = 8'h00;
    end

    // Strobe for exactly one taking edge, then release
    task automatic port_cycle(input logic wr, input logic [15:0] a, input logic [7:0] d);
        @(negedge core_clk);
        io_sel = 1'b1;
        io_write = wr;
        io_addr = a;
        io_wdata = d;
        @(negedge core_clk);
        io_sel = 1'b0;
        io_write = ~wr; // Released lines invert so a stale value is never mistaken
        io_addr = ~a;
        io_wdata = ~d;
    endtask
endmodule // legacy_host_model

/* tb/tb.sv */
`timescale 1ns/1ps

module tb
    import legacy_kbd_pkg::*;
;
    typedef struct packed {logic src; logic [31:0] val; logic [31:0] mask;} note_s;
    logic        core_clk, rst_n, mem_sel, mem_write, io_sel, io_write, io_claim, rd_seen;
    logic [8:0]  mem_addr;
    logic [31:0] mem_wdata, mem_rdata;
    logic [15:0] io_addr;
    logic [7:0]  io_wdata, io_rdata, ob, db;
    logic        kbc_kbd_irq, kbc_mouse_irq, keyboard_irq_line, mouse_irq_line, emulation_irq;
    note_s       exp_q[$];
    note_s       note;
    int          n_mismatch, cmp_count, k;

    legacy_kbd_emul u_legacy_kbd_emul (.core_clk(core_clk), .rst_n(rst_n), .mem_sel(mem_sel),
        .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .io_sel(io_sel), .io_write(io_write), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .io_claim(io_claim),
        .kbc_kbd_irq(kbc_kbd_irq), .kbc_mouse_irq(kbc_mouse_irq),
        .keyboard_irq_line(keyboard_irq_line), .mouse_irq_line(mouse_irq_line),
        .emulation_irq(emulation_irq));
    legacy_host_model u_legacy_host_model (.core_clk(core_clk), .io_sel(io_sel),
        .io_write(io_write), .io_addr(io_addr), .io_wdata(io_wdata));

    ////////////////////////////////////////////////////////////////////////////
    // Clock, and a marker for memory reads whose data lands next cycle
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        rd_seen <= mem_sel & ~mem_write & rst_n;
    end

    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Memory cycle: one strobe, released address and data inverted
    task automatic mem_cyc(input logic wr, input logic [8:0] a, input logic [31:0] d);
        @(negedge core_clk);
        mem_sel = 1'b1;
        mem_write = wr;
        mem_addr = a;
        mem_wdata = d & 32'h0000_01ff;
        @(negedge core_clk);
        mem_sel = 1'b0;
        mem_addr = ~a;
        mem_wdata = ~mem_wdata;
    endtask

    task automatic mem_rd(input logic [8:0] a, input logic [31:0] e);
        exp_q.push_back('{1'b1, e, 32'hffff_ffff});
        mem_cyc(1'b0, a, 32'h0);
    endtask

    // Port cycle through the host model; a write only expects its claim
    task automatic io(input logic wr, input logic [15:0] a, input logic [7:0] d,
                      input logic [7:0] e);
        exp_q.push_back('{1'b0, {24'h0, e}, wr ? 32'h0 : 32'hff});
        u_legacy_host_model.port_cycle(wr, a, d);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Monitor: every claim or read answer takes the oldest note
    always @(negedge core_clk) begin
        if (io_claim === 1'b1 || rd_seen === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_mismatch++;
                $display("unexpected answer expected none seen claim %b", io_claim);
            end else begin
                note = exp_q.pop_front();
                if (note.src) chk("mem_rdata", note.val, mem_rdata);
                else chk("io_rdata", note.val, {24'h0, io_rdata} & note.mask);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        rd_seen = 1'b0;
        mem_sel = 1'b0;
        mem_write = 1'b0;
        mem_addr = 9'h000;
        mem_wdata = 32'h0;
        kbc_kbd_irq = 1'b0;
        kbc_mouse_irq = 1'b0;
        void'($urandom(32'ha9869179));
        ob = 8'($urandom());
        db = 8'($urandom());
        cyc(8);
        rst_n = 1'b1;
        for (k = 0; k < 5; k++) mem_rd(9'h100 + 9'(4 * k), 32'h0);
        u_legacy_host_model.port_cycle(1'b0, PORT_DATA, 8'h00);
        u_legacy_host_model.port_cycle(1'b1, PORT_CMD, CMD_GATE_A20);
        mem_rd(OFS_CONTROL, 32'h0);
        mem_cyc(1'b1, OFS_OUTPUT, {24'h0, ob});
        mem_cyc(1'b1, OFS_CONTROL, 32'h001);
        mem_cyc(1'b1, OFS_STATUS, 32'h009);
        mem_rd(OFS_CONTROL, 32'h001);
        io(1'b0, PORT_DATA, 8'h00, ob);
        mem_rd(OFS_STATUS, 32'h008);
        io(1'b1, PORT_DATA, db, 8'h00);
        mem_rd(OFS_INPUT, {24'h0, db});
        mem_rd(OFS_STATUS, 32'h002);
        mem_rd(OFS_CONTROL, 32'h003);
        io(1'b0, PORT_CMD, 8'h00, 8'h02);
        mem_rd(OFS_STATUS, 32'h002);
        io(1'b1, PORT_CMD, CMD_GATE_A20, 8'h00);
        mem_rd(OFS_INPUT, 32'h0d1);
        mem_rd(OFS_STATUS, 32'h008);
        mem_rd(OFS_CONTROL, 32'h021);
        io(1'b1, PORT_CMD, 8'h20, 8'h00);
        // A command write pulses the emulation interrupt; let bit 1 settle first
        cyc(2);
        mem_rd(OFS_CONTROL, 32'h001);
        mem_cyc(1'b1, OFS_CONTROL, 32'h101);
        mem_rd(OFS_CONTROL, 32'h101);
        // Buffer interrupt steered by the auxiliary flag
        mem_cyc(1'b1, OFS_STATUS, 32'h001);
        mem_cyc(1'b1, OFS_CONTROL, 32'h009);
        cyc(3);
        chk("keyboard_irq_line", 32'h1, {31'h0, keyboard_irq_line});
        chk("mouse_irq_line", 32'h0, {31'h0, mouse_irq_line});
        mem_cyc(1'b1, OFS_STATUS, 32'h021);
        cyc(3);
        chk("mouse_irq_line", 32'h1, {31'h0, mouse_irq_line});
        chk("keyboard_irq_line", 32'h0, {31'h0, keyboard_irq_line});
        io(1'b0, PORT_DATA, 8'h00, ob);
        cyc(3);
        chk("mouse_irq_line", 32'h0, {31'h0, mouse_irq_line});
        // Character pending interrupt when the output buffer empties
        mem_cyc(1'b1, OFS_CONTROL, 32'h005);
        mem_cyc(1'b1, OFS_STATUS, 32'h001);
        cyc(3);
        chk("emulation_irq", 32'h0, {31'h0, emulation_irq});
        io(1'b0, PORT_DATA, 8'h00, ob);
        cyc(3);
        chk("emulation_irq", 32'h1, {31'h0, emulation_irq});
        mem_rd(OFS_CONTROL, 32'h007);
        mem_cyc(1'b1, OFS_CONTROL, 32'h001);
        cyc(3);
        chk("emulation_irq", 32'h0, {31'h0, emulation_irq});
        // External edges pass through with emulation itself disabled
        mem_cyc(1'b1, OFS_CONTROL, 32'h010);
        for (int i = 0; i < 2; i++) begin
            @(negedge core_clk);
            if (i == 0) kbc_kbd_irq = 1'b1;
            else kbc_mouse_irq = 1'b1;
            for (k = 0; k < 20 && emulation_irq !== 1'b1; k++) cyc(1);
            chk("emulation_irq", 32'h1, {31'h0, emulation_irq});
            mem_rd(OFS_CONTROL, i == 0 ? 32'h052 : 32'h092);
            kbc_kbd_irq = 1'b0;
            kbc_mouse_irq = 1'b0;
            mem_cyc(1'b1, OFS_CONTROL, 32'h0d0);
            cyc(3);
            mem_rd(OFS_CONTROL, 32'h010);
            chk("emulation_irq", 32'h0, {31'h0, emulation_irq});
        end
        cyc(4);
        chk("pending answers", 32'h0, 32'(exp_q.size()));
        print_verdict();
    end
endmodule // tb
